/* lvg_top.sv */
/*
 * apb slave holding the control registers of three low-voltage pins,
 * the pin drivers, pad setting outputs, debounce and edge interrupts.
 * assumes pins arrive asynchronously and pads decode the setting outputs.
 */
`timescale 1ns/1ps
`default_nettype none
module lvg_top
    import lvg_pkg::*;
#(
    parameter int unsigned T1 = DBNC1_CYC,
    parameter int unsigned T2 = DBNC2_CYC,
    parameter int unsigned T3 = DBNC3_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [2:0] lv_pin_in,
    output logic [2:0] lv_pin_out,
    output logic [2:0] lv_pin_oe,
    output logic [2:0] schmitt_select,
    output logic [2:0] keeper_enable,
    output logic [2:0] opendrain_enable,
    output logic [2:0] drive_strength_select,
    output logic [2:0] pull_enable,
    output logic [5:0] pull_select,
    output logic [5:0] slew_select,
    output logic irq
);
    logic [REG_W-1:0] ctrl [NUM_PINS];
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] filt;
    logic [2:0] filt_d;
    logic [2:0] edge_ev;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic [7:0] idx;
    logic wr_en;
    logic rd_en;
    logic hit;
    logic [31:0] next_prdata;
    logic [REG_W-1:0] wmask;
    logic [2:0] rise_ev;
    logic [2:0] fall_ev;
    logic [2:0] sel_pin;
    logic sel_status;
    logic sel_mask;
    logic status_wr;
    logic mask_wr;
    logic access;
    logic [2:0] pending;
    logic [2:0] next_irq_status;
    logic [2:0] next_pin_out;
    logic [2:0] next_pin_oe;

    // din reads back although the bus never stores it
    localparam logic [REG_W-1:0] RD_MASK = WR_MASK | (REG_W'(1) << B_DIN);
    // an undriven pin idles at the default pull level, so the flops start there
    localparam logic IDLE_LEVEL = CTRL_RESET[B_PULL_HI];

    assign idx = paddr[9:2];
    // an access cycle not yet answered; registers act on this edge
    assign access = psel && penable && !pready;
    assign wr_en = access && pwrite;
    assign rd_en = access && !pwrite;
    assign hit = (idx == IDX_PIN0) || (idx == IDX_PIN1) || (idx == IDX_PIN2)
                 || (idx == IDX_IRQ_STATUS) || (idx == IDX_IRQ_MASK);
    // one select per register keeps the write processes short
    assign sel_status = (idx == IDX_IRQ_STATUS);
    assign sel_mask = (idx == IDX_IRQ_MASK);
    // status and mask live in lane 0 only
    assign status_wr = wr_en && sel_status && pstrb[0];
    assign mask_wr = wr_en && sel_mask && pstrb[0];
    // unmasked events feed the interrupt flop
    assign pending = irq_status & irq_mask;
    // byte enables gate the writable mask lane by lane
    assign wmask = WR_MASK & {{8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

    // first synchroniser stage; nothing but the second stage reads it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= {NUM_PINS{IDLE_LEVEL}};
        end else begin
            sync1 <= lv_pin_in;
        end
    end

    // second stage, the only view of the pins that the logic gets
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync2 <= {NUM_PINS{IDLE_LEVEL}};
        end else begin
            sync2 <= sync1;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_PINS; g++) begin : g_pin
            // register select for this pin
            assign sel_pin[g] = (idx == IDX_PIN0 + 8'(g));

            lvg_debounce #(
                .T1(T1),
                .T2(T2),
                .T3(T3)
            ) u_dbnc (
                .pclk(pclk),
                .presetn(presetn),
                .sync_in(sync2[g]),
                .sel(ctrl[g][B_DBNC_HI:B_DBNC_LO]),
                .level(filt[g])
            );

            // edges of the filtered level, both kinds kept apart
            assign rise_ev[g] = !filt_d[g] && filt[g];
            assign fall_ev[g] = filt_d[g] && !filt[g];

            // interrupt kind picks which edges raise an event
            always_comb begin
                unique case (ctrl[g][B_INT_HI:B_INT_LO])
                    INT_NONE: edge_ev[g] = 1'b0;
                    INT_FALL: edge_ev[g] = fall_ev[g];
                    INT_RISE: edge_ev[g] = rise_ev[g];
                    INT_BOTH: edge_ev[g] = rise_ev[g] || fall_ev[g];
                endcase
            end

            // control register; din is hardware-owned and never stored by a write
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    ctrl[g] <= CTRL_RESET;
                end else begin
                    if (wr_en && sel_pin[g]) begin
                        ctrl[g] <= (ctrl[g] & ~wmask) | (pwdata[REG_W-1:0] & wmask);
                    end
                    ctrl[g][B_DIN] <= filt[g];
                end
            end

            // open drain only ever pulls low, else releases
            always_comb begin
                if (ctrl[g][B_OD]) begin
                    next_pin_out[g] = 1'b0;
                    next_pin_oe[g] = ctrl[g][B_DIR] && !ctrl[g][B_DOUT];
                end else begin
                    next_pin_out[g] = ctrl[g][B_DOUT];
                    next_pin_oe[g] = ctrl[g][B_DIR];
                end
            end

            // pin drive level, straight from a flop
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    lv_pin_out[g] <= CTRL_RESET[B_DOUT];
                end else begin
                    lv_pin_out[g] <= next_pin_out[g];
                end
            end

            // pin drive enable; lags the register write by one cycle
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    lv_pin_oe[g] <= CTRL_RESET[B_DIR];
                end else begin
                    lv_pin_oe[g] <= next_pin_oe[g];
                end
            end

            // receiver type
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    schmitt_select[g] <= CTRL_RESET[B_SCHMITT];
                end else begin
                    schmitt_select[g] <= ctrl[g][B_SCHMITT];
                end
            end

            // pad keeper
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    keeper_enable[g] <= CTRL_RESET[B_KEEPER];
                end else begin
                    keeper_enable[g] <= ctrl[g][B_KEEPER];
                end
            end

            // output stage kind for the pad
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    opendrain_enable[g] <= CTRL_RESET[B_OD];
                end else begin
                    opendrain_enable[g] <= ctrl[g][B_OD];
                end
            end

            // drive strength
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    drive_strength_select[g] <= CTRL_RESET[B_DRIVE];
                end else begin
                    drive_strength_select[g] <= ctrl[g][B_DRIVE];
                end
            end

            // pull resistor on or off
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pull_enable[g] <= CTRL_RESET[B_PULL_EN];
                end else begin
                    pull_enable[g] <= ctrl[g][B_PULL_EN];
                end
            end

            // pull direction and strength, high bit means up
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pull_select[2*g +: 2] <= CTRL_RESET[B_PULL_HI:B_PULL_LO];
                end else begin
                    pull_select[2*g +: 2] <= ctrl[g][B_PULL_HI:B_PULL_LO];
                end
            end

            // output slew
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    slew_select[2*g +: 2] <= CTRL_RESET[B_SLEW_HI:B_SLEW_LO];
                end else begin
                    slew_select[2*g +: 2] <= ctrl[g][B_SLEW_HI:B_SLEW_LO];
                end
            end
        end
    endgenerate

    // previous filtered level for the edge detectors
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            filt_d <= {NUM_PINS{IDLE_LEVEL}}; // no false edge once the pins settle
        end else begin
            filt_d <= filt;
        end
    end

    // new edges are or-ed in after the write-one clear, so the set wins
    always_comb begin
        next_irq_status = irq_status | edge_ev;
        if (status_wr) begin
            next_irq_status = (irq_status & ~pwdata[2:0]) | edge_ev;
        end
    end

    // sticky status bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= 3'h0;
        end else begin
            irq_status <= next_irq_status;
        end
    end

    // interrupt mask, one enables the bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask <= 3'h0;
        end else if (mask_wr) begin
            irq_mask <= pwdata[2:0];
        end
    end

    // level interrupt, registered so it lags status by one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |pending;
        end
    end

    // read mux; upper bits always zero
    always_comb begin
        next_prdata = 32'h0;
        unique case (idx)
            IDX_PIN0: next_prdata = {8'h0, ctrl[0] & RD_MASK};
            IDX_PIN1: next_prdata = {8'h0, ctrl[1] & RD_MASK};
            IDX_PIN2: next_prdata = {8'h0, ctrl[2] & RD_MASK};
            IDX_IRQ_STATUS: next_prdata = {29'h0, irq_status};
            IDX_IRQ_MASK: next_prdata = {29'h0, irq_mask};
            default: next_prdata = 32'h0;
        endcase
    end

    // one wait state: pready rises the cycle after the access phase begins,
    // a cycle of latency traded for answer signals straight from flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= access;
        end
    end

    // error flag rides with pready on an unmapped index
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= access && !hit;
        end
    end

    // read data stands only with pready, zero otherwise
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else begin
            prdata <= rd_en ? next_prdata : 32'h0;
        end
    end
endmodule
`default_nettype wire

/* lvg_pkg.sv */
/*
 * package for the low-voltage pin control block: register indices,
 * field positions, reset values and debounce timing.
 * assumes a 25 MHz apb clock and 32-bit apb data.
 */
package lvg_pkg;
    localparam int unsigned CLK_HZ = 25000000;
    localparam int unsigned NUM_PINS = 3;
    // register indices as printed; byte address is four times the index
    localparam logic [7:0] IDX_PIN0 = 8'h21;
    localparam logic [7:0] IDX_PIN1 = 8'h22;
    localparam logic [7:0] IDX_PIN2 = 8'h23;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h30;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h31;
    localparam int unsigned REG_W = 24;
    // field positions
    localparam int unsigned B_DIR = 0;
    localparam int unsigned B_DIN = 1;
    localparam int unsigned B_DOUT = 2;
    localparam int unsigned B_SCHMITT = 3;
    localparam int unsigned B_DBNC_LO = 4;
    localparam int unsigned B_DBNC_HI = 5;
    localparam int unsigned B_INT_LO = 6;
    localparam int unsigned B_INT_HI = 7;
    localparam int unsigned B_KEEPER = 8;
    localparam int unsigned B_OD = 9;
    localparam int unsigned B_DRIVE = 10;
    localparam int unsigned B_PULL_EN = 11;
    localparam int unsigned B_PULL_LO = 12;
    localparam int unsigned B_PULL_HI = 13;
    localparam int unsigned B_SLEW_LO = 14;
    localparam int unsigned B_SLEW_HI = 15;
    // writable bits 15..0, upper bits 23..16 read zero, din is read only
    localparam logic [23:0] WR_MASK = 24'h00fffd;
    localparam logic [23:0] CTRL_RESET = 24'h003808;
    // interrupt selections
    localparam logic [1:0] INT_NONE = 2'h0;
    localparam logic [1:0] INT_FALL = 2'h1;
    localparam logic [1:0] INT_RISE = 2'h2;
    localparam logic [1:0] INT_BOTH = 2'h3;
    // debounce times in ms and their cycle counts
    localparam int unsigned DBNC1_MS = 10;
    localparam int unsigned DBNC2_MS = 20;
    localparam int unsigned DBNC3_MS = 30;
    localparam int unsigned DBNC1_CYC = DBNC1_MS * (CLK_HZ / 1000);
    localparam int unsigned DBNC2_CYC = DBNC2_MS * (CLK_HZ / 1000);
    localparam int unsigned DBNC3_CYC = DBNC3_MS * (CLK_HZ / 1000);
    localparam int unsigned CNT_W = 20;
endpackage

/* lvg_debounce.sv */
/*
 * one-pin debounce filter with selectable settling time.
 * assumes its input is already synchronised to pclk.
 */
`timescale 1ns/1ps
`default_nettype none
module lvg_debounce
    import lvg_pkg::*;
#(
    parameter int unsigned T1 = DBNC1_CYC,
    parameter int unsigned T2 = DBNC2_CYC,
    parameter int unsigned T3 = DBNC3_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic sync_in,
    input wire logic [1:0] sel,
    output logic level
);
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] limit;

    // settle time for the chosen setting
    always_comb begin
        unique case (sel)
            2'h0: limit = '0;
            2'h1: limit = CNT_W'(T1 - 1);
            2'h2: limit = CNT_W'(T2 - 1);
            2'h3: limit = CNT_W'(T3 - 1);
        endcase
    end

    // level follows only after the input has held steady for the whole time
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= '0;
            level <= CTRL_RESET[B_PULL_HI]; // idle pin reads high under the default pull
        end else if (sel == 2'h0 || sync_in == level) begin
            count <= '0;
            level <= sync_in;
        end else if (count >= limit) begin
            count <= '0;
            level <= sync_in;
        end else begin
            count <= count + CNT_W'(1);
        end
    end
endmodule
`default_nettype wire

/* lvg_top_monitor.sv */
/* port checks for lvg_top: apb timing, read data, pad outputs.
   assumes one pclk domain; bound onto lvg_top below. */
`timescale 1ns/1ps
`default_nettype none
module lvg_monitor
    import lvg_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [2:0] lv_pin_out,
    input wire logic [2:0] lv_pin_oe,
    input wire logic [2:0] opendrain_enable,
    input wire logic [2:0] schmitt_select,
    input wire logic [5:0] pull_select,
    input wire logic irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // decoded apart so a wrong index shows up as a wrong error flag
    wire logic hit = paddr[9:2] inside {IDX_PIN0, IDX_PIN1, IDX_PIN2, IDX_IRQ_STATUS,
        IDX_IRQ_MASK};
    one_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("access not answered after one wait");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held too long");
    ready_access_a: assert property (pready |-> psel && penable)
        else $error("ready outside an access");
    slverr_map_a: assert property (pready |-> pslverr == !hit)
        else $error("error flag disagrees with map");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer");
    upper_zero_a: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0)
        else $error("upper bits not zero");
    od_no_high_a: assert property ((opendrain_enable & lv_pin_oe & lv_pin_out) == 3'h0)
        else $error("open drain drove high");
    pad_reset_a: assert property ($rose(presetn) |->
        schmitt_select == 3'h7 && pull_select == 6'h3f && lv_pin_oe == 3'h0)
        else $error("pads not at defaults");
    cover property (pready && pwrite && !pslverr);
    cover property (pready && !pwrite && prdata != 32'h0);
    cover property (pready && pslverr);
    cover property ($rose(irq));
endmodule
bind lvg_top lvg_monitor mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata,
    .pready, .pslverr, .lv_pin_out, .lv_pin_oe, .opendrain_enable, .schmitt_select,
    .pull_select, .irq);
`default_nettype wire

/* lvg_pin_model.sv */
/* pin model: resolves each pin from the block's drive, an outside driver
   and the pad pull. assumes the bench owns ext_oe and ext_val. */
`timescale 1ns/1ps
`default_nettype none
module lvg_pin_model (
    input wire logic pclk,
    input wire logic [2:0] lv_pin_out,
    input wire logic [2:0] lv_pin_oe,
    input wire logic [2:0] pull_enable,
    input wire logic [5:0] pull_select,
    input wire logic [2:0] ext_oe,
    input wire logic [2:0] ext_val,
    output logic [2:0] lv_pin_in
);
    logic flip = 1'b0;
    // a floating pad must never look stable
    always @(posedge pclk) flip <= ~flip;
    // block drive wins, then outside driver, then pull (high bit means up)
    always_comb begin
        for (int g = 0; g < 3; g++) begin
            if (lv_pin_oe[g]) lv_pin_in[g] = lv_pin_out[g];
            else if (ext_oe[g]) lv_pin_in[g] = ext_val[g];
            else if (pull_enable[g]) lv_pin_in[g] = pull_select[2*g+1];
            else lv_pin_in[g] = flip;
        end
    end
endmodule
`default_nettype wire

/* low_voltage_gpio_control_tb_top.sv */
/* bench for the low-voltage pin block: apb master tasks, one task per
   scenario. assumes the monitor binds itself; debounce counts 4/8/12. */
`timescale 1ns/1ps
`default_nettype none
module low_voltage_gpio_control_tb_top
    import lvg_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic [2:0] lv_pin_in, lv_pin_out, lv_pin_oe, schmitt_select, keeper_enable;
    logic [2:0] opendrain_enable, drive_strength_select, pull_enable, ext_oe, ext_val;
    logic [5:0] pull_select, slew_select;
    int err_total, cmp_count;
    lvg_top #(.T1(4), .T2(8), .T3(12)) uut (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .lv_pin_in, .lv_pin_out,
        .lv_pin_oe, .schmitt_select, .keeper_enable, .opendrain_enable,
        .drive_strength_select, .pull_enable, .pull_select, .slew_select, .irq);
    lvg_pin_model pins (.pclk, .lv_pin_out, .lv_pin_oe, .pull_enable, .pull_select,
        .ext_oe, .ext_val, .lv_pin_in);
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    task automatic tally_and_finish();
        if (err_total == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    // one transfer; waits on pready, bounded, then idles one cycle
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
            input logic [3:0] s, output logic [31:0] r, output logic e);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (n >= 20) begin
            err_total++;
            tally_and_finish();
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, 4'hf, r, e);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, 4'h0, r, e);
        chk(r, x);
        chk({31'h0, e}, {31'h0, xe});
    endtask
    task automatic t_defaults();
        for (int g = 0; g < 3; g++) rd(12'h84 + 12'(4 * g), 32'h380a, 1'b0);
        chk({14'h0, schmitt_select, pull_enable, pull_select, slew_select}, 32'h3ffc0);
        rd(12'hc4, 32'h0, 1'b0);
        rd(12'h100, 32'h0, 1'b1);
    endtask
    task automatic t_fields();
        logic [31:0] r;
        logic e;
        wr(12'h88, 32'hffffffff);
        rd(12'h88, 32'hffff, 1'b0);
        chk({24'h0, keeper_enable[1], opendrain_enable[1], drive_strength_select[1],
            pull_select[3:2], slew_select[3:2], lv_pin_oe[1]}, 32'hfe);
        apb(1'b1, 12'h88, 32'h0, 4'h1, r, e);
        rd(12'h88, 32'hff02, 1'b0);
    endtask
    task automatic t_drive();
        wr(12'h8c, 32'h5);
        chk({29'h0, schmitt_select[2], lv_pin_oe[2], lv_pin_out[2]}, 32'h3);
        repeat (8) @(posedge pclk);
        rd(12'h8c, 32'h7, 1'b0);
        wr(12'h8c, 32'h3a0d);
        chk({30'h0, lv_pin_oe[2], lv_pin_out[2]}, 32'h0);
        repeat (8) @(posedge pclk);
        rd(12'h8c, 32'h3a0f, 1'b0);
    endtask
    task automatic t_pull();
        for (int s = 0; s < 4; s++) begin
            wr(12'h84, 32'h800 | (s << 12));
            repeat (8) @(posedge pclk);
            rd(12'h84, 32'h800 | (s << 12) | (s & 2), 1'b0);
        end
    endtask
    task automatic t_edges();
        ext_oe[0] <= 1'b1;
        wr(12'hc4, 32'h1);
        for (int k = 0; k < 4; k++) begin
            wr(12'h84, 32'(k << 6));
            wr(12'hc0, 32'h7);
            ext_val[0] <= 1'b1;
            repeat (10) @(posedge pclk);
            chk({31'h0, irq}, 32'(k >> 1));
            wr(12'hc0, 32'h7);
            ext_val[0] <= 1'b0;
            repeat (10) @(posedge pclk);
            rd(12'hc0, 32'(k & 1), 1'b0);
        end
        wr(12'hc4, 32'h0);
        chk({31'h0, irq}, 32'h0); // masked status keeps irq low
    endtask
    task automatic t_debounce();
        wr(12'hc4, 32'h1);
        for (int d = 1; d < 4; d++) begin
            wr(12'h84, 32'((d << 4) | 8'h80));
            wr(12'hc0, 32'h7);
            ext_val[0] <= 1'b1;
            repeat (4 * d - 2) @(posedge pclk);
            ext_val[0] <= 1'b0;
            repeat (20) @(posedge pclk);
            rd(12'hc0, 32'h0, 1'b0);
            ext_val[0] <= 1'b1;
            repeat (4 * d) @(posedge pclk);
            chk({31'h0, irq}, 32'h0);
            repeat (8) @(posedge pclk);
            chk({31'h0, irq}, 32'h1);
            ext_val[0] <= 1'b0;
            repeat (20) @(posedge pclk);
        end
    endtask
    initial begin
        {psel, penable, pwrite, paddr, pwdata, pstrb, ext_oe, ext_val} = '0;
        err_total = 0;
        cmp_count = 0;
        presetn = 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        repeat (8) @(posedge pclk);
        t_defaults();
        t_fields();
        t_drive();
        t_pull();
        t_edges();
        t_debounce();
        ext_oe <= 3'h0;
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (8) @(posedge pclk);
        t_defaults();
        tally_and_finish();
    end
endmodule
`default_nettype wire
